// *** verilog/ibs_pkg.sv ***
// Constants shared by the two-wire master bus-status block.
package ibs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_BIT_RATE = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_SYNC = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_TARGET = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h28;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ST_ILLEGAL = 0;
  localparam int ST_CONTENTION = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_OWN_LO = 4;
  localparam int ST_TIMEOUT = 6;
  localparam int SYNC_SYSOP = 2;
  localparam int IRQ_MASTER = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_W = 2;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [31:0] BIT_RATE_RST = 32'h0000_0000;
  localparam logic [7:0] TARGET_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] OWN_UNKNOWN = 2'h0;
  localparam logic [1:0] OWN_IDLE = 2'h1;
  localparam logic [1:0] OWN_OWNER = 2'h2;
  localparam logic [1:0] OWN_BUSY = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ = 20000;
  localparam int LOW_TIMEOUT_MS = 25;
  localparam int LOW_TIMEOUT_CYCLES = LOW_TIMEOUT_MS * CLK_KHZ;

  typedef enum logic [1:0] {IBS_UNKNOWN, IBS_IDLE, IBS_OWNER, IBS_BUSY} ibs_own_t;

endpackage

// *** verilog/ibs_line_monitor.sv ***
// Line condition monitor: pin synchronisers, start and stop detection, time-out.
`timescale 1ns/1ns
`default_nettype none
module ibs_line_monitor #(
  parameter int unsigned TIMEOUT_CYCLES = ibs_pkg::LOW_TIMEOUT_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Line pins.
  input wire logic scl_i,
  input wire logic sda_i,
  // Detected conditions, one-cycle pulses.
  output logic start_o,
  output logic stop_o,
  output logic violation_o,
  output logic timeout_o
);

  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_prv;
  logic sda_prv;
  logic in_frame;
  logic clocked;
  logic [CNT_W-1:0] low_cnt;
  logic start_det;
  logic stop_det;
  logic low_expired;

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  // A level is accepted only once the second and third stage agree, which filters one-cycle glitches.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      scl_prv <= 1'b1;
      sda_prv <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_lvl <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_lvl <= sda_sync[2];
      end
      scl_prv <= scl_lvl;
      sda_prv <= sda_lvl;
    end
  end

  // ****************************************************************
  // Conditions
  // ****************************************************************
  assign start_det = scl_lvl & scl_prv & sda_prv & ~sda_lvl;
  assign stop_det = scl_lvl & scl_prv & ~sda_prv & sda_lvl;
  assign low_expired = in_frame & ~scl_lvl & (low_cnt == CNT_LAST);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_frame <= 1'b0;
      clocked <= 1'b0;
      low_cnt <= '0;
    end else begin
      if (start_det) begin
        in_frame <= 1'b1;
        clocked <= 1'b0;
      end else if (stop_det || low_expired) begin
        in_frame <= 1'b0;
      end else if (scl_prv && !scl_lvl) begin
        clocked <= 1'b1;
      end
      if (in_frame && !scl_lvl && !low_expired) begin
        low_cnt <= low_cnt + 1'b1;
      end else begin
        low_cnt <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_o <= 1'b0;
      stop_o <= 1'b0;
      violation_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      start_o <= start_det;
      stop_o <= stop_det;
      // A stop or a repeated start with no clock since the start breaks the protocol.
      violation_o <= in_frame & ~clocked & (start_det | stop_det);
      timeout_o <= low_expired;
    end
  end

endmodule // ibs_line_monitor
`default_nettype wire

// *** verilog/ibs_status.sv ***
// Bus ownership tracking, status flags, register port and interrupt of the two-wire master.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module ibs_status #(
  parameter int unsigned TIMEOUT_CYCLES = ibs_pkg::LOW_TIMEOUT_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Line pins.
  input wire logic scl_i,
  input wire logic sda_i,
  // Byte engine events, same clock.
  input wire logic eng_start_won_i,
  input wire logic eng_arb_lost_i,
  input wire logic eng_ack_i,
  input wire logic eng_nack_i,
  // Block outputs.
  output logic irq_o,
  output logic [31:0] bit_rate_o,
  output logic [7:0] target_addr_o,
  output logic target_wr_o,
  output logic [1:0] ownership_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ibs_pkg::ibs_own_t own_state;
  ibs_pkg::ibs_own_t next_own_state;
  logic line_start;
  logic line_stop;
  logic line_violation;
  logic line_timeout;
  logic wr_status;
  logic wr_target;
  logic wr_bit_rate;
  logic wr_irq_enable;
  logic wr_irq_clear;
  logic force_idle_req;
  logic sync_pending;
  logic illegal_flag;
  logic contention_flag;
  logic refused_flag;
  logic timeout_flag;
  logic illegal_set;
  logic contention_set;
  logic clr_contention;
  logic clr_timeout;
  logic [ibs_pkg::IRQ_W-1:0] irq_status;
  logic [ibs_pkg::IRQ_W-1:0] irq_enable;
  logic [ibs_pkg::IRQ_W-1:0] irq_set;
  logic [15:0] status_word;
  logic [31:0] next_rdata;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [1:0] own_code(input ibs_pkg::ibs_own_t st);
    case (st)
      ibs_pkg::IBS_UNKNOWN: own_code = ibs_pkg::OWN_UNKNOWN;
      ibs_pkg::IBS_IDLE: own_code = ibs_pkg::OWN_IDLE;
      ibs_pkg::IBS_OWNER: own_code = ibs_pkg::OWN_OWNER;
      ibs_pkg::IBS_BUSY: own_code = ibs_pkg::OWN_BUSY;
      default: own_code = ibs_pkg::OWN_UNKNOWN;
    endcase
  endfunction

  // Any target address write clears the flag, and so does a status write of one to its bit.
  function automatic logic flag_clear(input logic st_wr, input logic tg_wr, input logic bit_one);
    flag_clear = tg_wr | (st_wr & bit_one);
  endfunction

  // ****************************************************************
  // Line monitor
  // ****************************************************************
  ibs_line_monitor #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_line_monitor (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .start_o(line_start),
    .stop_o(line_stop),
    .violation_o(line_violation),
    .timeout_o(line_timeout)
  );

  // ****************************************************************
  // Write decode
  // ****************************************************************
  assign wr_status = reg_wr_i & hit(reg_addr_i, ibs_pkg::OFF_STATUS);
  assign wr_target = reg_wr_i & hit(reg_addr_i, ibs_pkg::OFF_TARGET);
  assign wr_bit_rate = reg_wr_i & hit(reg_addr_i, ibs_pkg::OFF_BIT_RATE);
  assign wr_irq_enable = reg_wr_i & hit(reg_addr_i, ibs_pkg::OFF_IRQ_ENABLE);
  assign wr_irq_clear = reg_wr_i & hit(reg_addr_i, ibs_pkg::OFF_IRQ_CLEAR);

  // Only the idle code in the ownership field asks for a force; other codes are dropped.
  assign force_idle_req = wr_status &
    (reg_wdata_i[ibs_pkg::ST_OWN_LO +: 2] == ibs_pkg::OWN_IDLE);

  // ****************************************************************
  // Plain configuration registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_rate_o <= ibs_pkg::BIT_RATE_RST;
    end else if (wr_bit_rate) begin
      bit_rate_o <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      target_addr_o <= ibs_pkg::TARGET_RST;
    end else if (wr_target) begin
      target_addr_o <= reg_wdata_i[7:0];
    end
  end

  // The engine is told one cycle after the write, when the new address already stands.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      target_wr_o <= 1'b0;
    end else begin
      target_wr_o <= wr_target;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_enable <= ibs_pkg::IRQ_RST;
    end else if (wr_irq_enable) begin
      irq_enable <= reg_wdata_i[ibs_pkg::IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // System operation synchronisation
  // ****************************************************************
  // The force is applied one cycle after the write, the pending bit covering that gap.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_pending <= 1'b0;
    end else begin
      sync_pending <= force_idle_req;
    end
  end

  // ****************************************************************
  // Ownership state
  // ****************************************************************
  always_comb begin
    next_own_state = own_state;
    case (own_state)
      ibs_pkg::IBS_UNKNOWN: begin
        // Nothing but a stop or a software force leaves this state.
        if (line_stop || sync_pending) begin
          next_own_state = ibs_pkg::IBS_IDLE;
        end
      end
      ibs_pkg::IBS_IDLE: begin
        if (line_start) begin
          next_own_state = eng_start_won_i ? ibs_pkg::IBS_OWNER : ibs_pkg::IBS_BUSY;
        end
      end
      ibs_pkg::IBS_OWNER: begin
        if (line_violation || line_timeout) begin
          next_own_state = ibs_pkg::IBS_UNKNOWN;
        end else if (line_stop) begin
          next_own_state = ibs_pkg::IBS_IDLE;
        end else if (eng_arb_lost_i) begin
          next_own_state = ibs_pkg::IBS_BUSY;
        end
      end
      ibs_pkg::IBS_BUSY: begin
        if (line_timeout) begin
          next_own_state = ibs_pkg::IBS_UNKNOWN;
        end else if (line_stop) begin
          next_own_state = ibs_pkg::IBS_IDLE;
        end
      end
      default: begin
        next_own_state = ibs_pkg::IBS_UNKNOWN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      own_state <= ibs_pkg::IBS_UNKNOWN;
    end else begin
      own_state <= next_own_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ownership_o <= ibs_pkg::OWN_UNKNOWN;
    end else begin
      ownership_o <= own_code(next_own_state);
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  assign illegal_set = line_violation | line_timeout;
  // Losing the line and breaking the protocol while owning it both count as a contention loss.
  assign contention_set = eng_arb_lost_i |
    (illegal_set & (own_state == ibs_pkg::IBS_OWNER));
  assign clr_contention = flag_clear(wr_status, wr_target, reg_wdata_i[ibs_pkg::ST_CONTENTION]);
  assign clr_timeout = flag_clear(wr_status, wr_target, reg_wdata_i[ibs_pkg::ST_TIMEOUT]);

  // Flag writes act in the cycle of the write; hardware sets win over any clear.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      illegal_flag <= 1'b0;
    end else if (illegal_set) begin
      illegal_flag <= 1'b1;
    end else if (wr_target) begin
      illegal_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      contention_flag <= 1'b0;
    end else if (contention_set) begin
      contention_flag <= 1'b1;
    end else if (clr_contention) begin
      contention_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timeout_flag <= 1'b0;
    end else if (line_timeout) begin
      timeout_flag <= 1'b1;
    end else if (clr_timeout) begin
      timeout_flag <= 1'b0;
    end
  end

  // Software cannot touch this one; only the peer's answer moves it.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refused_flag <= 1'b0;
    end else if (eng_nack_i) begin
      refused_flag <= 1'b1;
    end else if (eng_ack_i) begin
      refused_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  assign irq_set[ibs_pkg::IRQ_MASTER] = contention_set | eng_ack_i | eng_nack_i;
  assign irq_set[ibs_pkg::IRQ_ERROR] = illegal_set;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= ibs_pkg::IRQ_RST;
    end else if (wr_irq_clear) begin
      irq_status <= (irq_status & ~reg_wdata_i[ibs_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb begin
    status_word = 16'h0000;
    status_word[ibs_pkg::ST_ILLEGAL] = illegal_flag;
    status_word[ibs_pkg::ST_CONTENTION] = contention_flag;
    status_word[ibs_pkg::ST_REFUSED] = refused_flag;
    status_word[ibs_pkg::ST_OWN_LO +: 2] = own_code(own_state);
    status_word[ibs_pkg::ST_TIMEOUT] = timeout_flag;
  end

  // Unmapped and write-only offsets read as zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr_i)
      ibs_pkg::OFF_BIT_RATE: begin
        next_rdata = bit_rate_o;
      end
      ibs_pkg::OFF_STATUS: begin
        next_rdata = {16'h0000, status_word};
      end
      ibs_pkg::OFF_SYNC: begin
        next_rdata[ibs_pkg::SYNC_SYSOP] = sync_pending;
      end
      ibs_pkg::OFF_IRQ_STATUS: begin
        next_rdata[ibs_pkg::IRQ_W-1:0] = irq_status;
      end
      ibs_pkg::OFF_IRQ_ENABLE: begin
        next_rdata[ibs_pkg::IRQ_W-1:0] = irq_enable;
      end
      ibs_pkg::OFF_TARGET: begin
        next_rdata[7:0] = target_addr_o;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule // ibs_status
`default_nettype wire

// *** tb/ibs_status_checker.sv ***
// Port-level assertions for the two-wire master bus-status block.
`timescale 1ns/1ns
`default_nettype none
module ibs_status_checker (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Engine event and block outputs.
  input wire logic eng_arb_lost_i,
  input wire logic [31:0] bit_rate_o,
  input wire logic [7:0] target_addr_o,
  input wire logic target_wr_o,
  input wire logic [1:0] ownership_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic st_wr;
  logic tg_wr;
  assign st_wr = reg_wr_i && reg_addr_i == ibs_pkg::OFF_STATUS;
  assign tg_wr = reg_wr_i && reg_addr_i == ibs_pkg::OFF_TARGET;
  force_idle_a:
  assert property (st_wr && reg_wdata_i[5:4] == 2'h1 ##1 ownership_o == 2'h0 |-> ##[1:2] ownership_o == 2'h1)
    else $error("forced idle not applied");
  no_force_a:
  assert property (st_wr && reg_wdata_i[5] && ownership_o == 2'h0 |=> (!ownership_o[1]) [*2])
    else $error("ownership forced to a non-idle code");
  unknown_exit_a:
  assert property (ownership_o == 2'h0 ##1 ownership_o != 2'h0 |-> ownership_o == 2'h1)
    else $error("unknown state left for other than idle");
  owner_entry_a:
  assert property (ownership_o == 2'h2 && !$stable(ownership_o) |-> $past(ownership_o) == 2'h1)
    else $error("owner state entered from other than idle");
  lost_owner_a:
  assert property (ownership_o == 2'h2 && eng_arb_lost_i |=> ownership_o == 2'h3)
    else $error("owner kept the line after contention loss");
  rate_copy_a:
  assert property (reg_wr_i && reg_addr_i == ibs_pkg::OFF_BIT_RATE |=> bit_rate_o == $past(reg_wdata_i))
    else $error("bit rate copy wrong");
  target_pulse_a:
  assert property (tg_wr |=> target_wr_o && {24'h0, target_addr_o} == ($past(reg_wdata_i) & 32'h0000_00ff))
    else $error("target write not passed on");
  target_quiet_a:
  assert property (!tg_wr |=> !target_wr_o)
    else $error("target pulse without a write");
  read_stands_a:
  assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule // ibs_status_checker
bind ibs_status ibs_status_checker chk_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .eng_arb_lost_i(eng_arb_lost_i), .bit_rate_o(bit_rate_o), .target_addr_o(target_addr_o),
  .target_wr_o(target_wr_o), .ownership_o(ownership_o));
`default_nettype wire

// *** tb/ibs_line_model.sv ***
// Behavioural model of the other masters and slaves on the two pulled-up lines.
`timescale 1ns/1ns
`default_nettype none
module ibs_line_model (
  // Line levels seen by the block.
  output logic scl_o,
  output logic sda_o
);
  // Both lines rest high through their pull-ups between frames.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Each step of start_c, rise and stop_c lasts ten block clocks, so the synchroniser has settled before the next.
  task automatic start_c;
    sda_o = 1'b0;
    #500;
  endtask
  task automatic rise;
    scl_o = 1'b1;
    #500;
    sda_o = 1'b1;
    #500;
  endtask
  task automatic stop_c;
    scl_o = 1'b0;
    #500;
    sda_o = 1'b0;
    #500;
    rise();
  endtask
  task automatic hold_low(input int n);
    scl_o = 1'b0;
    #(n * 50);
  endtask
endmodule // ibs_line_model
`default_nettype wire

// *** tb/ibs_status_test.sv ***
// Self-checking testbench of the bus-status block against a behavioural flag model.
`timescale 1ns/1ns
`default_nettype none
module ibs_status_test;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, eng_start_won_i = 1'b0;
  logic eng_arb_lost_i = 1'b0, eng_ack_i = 1'b0, eng_nack_i = 1'b0;
  logic scl, sda, irq_o, target_wr_o;
  logic [31:0] reg_rdata_o, bit_rate_o, v, d;
  logic [7:0] target_addr_o;
  logic [1:0] ownership_o;
  logic [7:0] rs [0:6] = '{8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h04};
  int err_count = 0, n_checks = 0, cyc = 0, own = 0, ill = 0, con = 0, rf = 0, tmo = 0, ist = 0, en = 0, i;
  int seed = 32'h80ad0da5;
  always #25 sys_clk_i = ~sys_clk_i;
  ibs_line_model line (.scl_o(scl), .sda_o(sda));
  // A short time-out keeps the run brief; the figure is a parameter of the block.
  ibs_status #(.TIMEOUT_CYCLES(64)) dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .scl_i(scl), .sda_i(sda), .eng_start_won_i(eng_start_won_i), .eng_arb_lost_i(eng_arb_lost_i),
    .eng_ack_i(eng_ack_i), .eng_nack_i(eng_nack_i), .irq_o(irq_o), .bit_rate_o(bit_rate_o),
    .target_addr_o(target_addr_o), .target_wr_o(target_wr_o), .ownership_o(ownership_o));
  // ****************************************************************
  // Model and bus tasks
  // ****************************************************************
  function automatic logic [31:0] st();
    return 32'(tmo * 64 + own * 16 + rf * 4 + con * 2 + ill);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // A set lost-contention flag may ride along with a write, to meet it in the same cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic l = 1'b0);
    @(posedge sys_clk_i) begin
      reg_addr_i <= a;
      reg_wdata_i <= dd;
      reg_wr_i <= 1'b1;
      eng_arb_lost_i <= l;
    end
    @(posedge sys_clk_i) begin
      reg_wr_i <= 1'b0;
      eng_arb_lost_i <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i) begin
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
    end
    @(posedge sys_clk_i) reg_rd_i <= 1'b0;
    @(negedge sys_clk_i) v = reg_rdata_o;
  endtask
  task automatic ev(input logic [2:0] m);
    @(posedge sys_clk_i) {eng_arb_lost_i, eng_ack_i, eng_nack_i} <= m;
    @(posedge sys_clk_i) {eng_arb_lost_i, eng_ack_i, eng_nack_i} <= 3'b000;
  endtask
  task automatic cs;
    repeat (3) @(posedge sys_clk_i);
    rd(ibs_pkg::OFF_STATUS);
    chk(v, st());
    rd(ibs_pkg::OFF_IRQ_STATUS);
    chk(v, ist);
    chk({31'h0, irq_o}, 32'((ist & en) != 0));
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      test_done();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    for (i = 0; i < 7; i++) begin
      rd(rs[i]);
      chk(v, 32'h0000_0000);
    end
    fin("reset");
    for (i = 2; i < 4; i++) begin
      wr(ibs_pkg::OFF_STATUS, 32'(i * 16));
      cs();
    end
    @(posedge sys_clk_i) begin
      reg_addr_i <= ibs_pkg::OFF_STATUS;
      reg_wdata_i <= 32'h0000_0010;
      reg_wr_i <= 1'b1;
    end
    @(posedge sys_clk_i) begin
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b1;
      reg_addr_i <= ibs_pkg::OFF_SYNC;
    end
    @(posedge sys_clk_i) reg_rd_i <= 1'b0;
    @(negedge sys_clk_i) chk(reg_rdata_o, 32'h0000_0004);
    own = 1;
    cs();
    fin("force");
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(ibs_pkg::OFF_BIT_RATE, d);
      rd(ibs_pkg::OFF_BIT_RATE);
      chk(v, d);
      chk(bit_rate_o, d);
    end
    fin("bit rate");
    eng_start_won_i <= 1'b1;
    line.start_c();
    own = 2;
    cs();
    ev(3'b010);
    ist = 1;
    cs();
    ev(3'b001);
    rf = 1;
    wr(ibs_pkg::OFF_STATUS, 32'h0000_0004);
    cs();
    ev(3'b100);
    con = 1;
    own = 3;
    cs();
    wr(ibs_pkg::OFF_STATUS, 32'h0000_0000);
    cs();
    wr(ibs_pkg::OFF_STATUS, 32'h0000_0002);
    con = 0;
    cs();
    eng_start_won_i <= 1'b0;
    line.stop_c();
    own = 1;
    cs();
    fin("owner");
    wr(ibs_pkg::OFF_IRQ_CLEAR, 32'h0000_0003);
    ist = 0;
    cs();
    wr(ibs_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
    en = 1;
    wr(ibs_pkg::OFF_IRQ_CLEAR, 32'h0000_0001, 1'b1);
    ist = 1;
    con = 1;
    cs();
    wr(ibs_pkg::OFF_STATUS, 32'h0000_0002, 1'b1);
    cs();
    wr(ibs_pkg::OFF_IRQ_ENABLE, 32'h0000_0002);
    en = 2;
    cs();
    fin("interrupt");
    line.start_c();
    own = 3;
    line.rise();
    ill = 1;
    ist = 3;
    line.stop_c();
    own = 1;
    cs();
    wr(ibs_pkg::OFF_TARGET, 32'h0000_005a);
    ill = 0;
    con = 0;
    cs();
    chk({24'h0, target_addr_o}, 32'h0000_005a);
    wr(ibs_pkg::OFF_IRQ_CLEAR, 32'h0000_0003);
    ist = 0;
    eng_start_won_i <= 1'b1;
    line.start_c();
    eng_start_won_i <= 1'b0;
    own = 2;
    line.rise();
    ill = 1;
    con = 1;
    ist = 3;
    own = 0;
    cs();
    wr(ibs_pkg::OFF_STATUS, 32'h0000_0010);
    wr(ibs_pkg::OFF_TARGET, 32'h0000_0033);
    own = 1;
    ill = 0;
    con = 0;
    cs();
    fin("violation");
    line.start_c();
    line.hold_low(100);
    ill = 1;
    tmo = 1;
    own = 0;
    cs();
    wr(ibs_pkg::OFF_STATUS, 32'h0000_0040);
    tmo = 0;
    cs();
    rd(ibs_pkg::OFF_SYNC);
    chk(v, 32'h0000_0000);
    line.rise();
    own = 1;
    cs();
    fin("time-out");
    test_done();
  end
endmodule // ibs_status_test
`default_nettype wire
